// ==== design/ocs_params.svh ====
// Offsets, field positions, reset values and limits of the command sync block.
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// ==========================================================================
// Register byte offsets.
`define OCS_ADDR_ESR 8'h00
`define OCS_ADDR_ESE 8'h04
`define OCS_ADDR_SRE 8'h08
`define OCS_ADDR_STB 8'h0C
`define OCS_ADDR_ERRQ 8'h10
`define OCS_ADDR_CTRL 8'h14
`define OCS_ADDR_STATE 8'h18

// ==========================================================================
// Field positions.
`define OCS_ESR_OPC 0
`define OCS_STB_ERRQ 2
`define OCS_STB_QUES 3
`define OCS_STB_MAV 4
`define OCS_STB_ESB 5
`define OCS_STB_RQS 6
`define OCS_STB_OPER 7
`define OCS_CTRL_DEFER 0
`define OCS_CTRL_LINEOVL 1

// ==========================================================================
// Reset values, answers and limits.
`define OCS_ESE_RST 8'h00
`define OCS_SRE_RST 8'h00
`define OCS_CTRL_RST 8'h00
`define OCS_OPCQ_VALUE 8'h01
`define OCS_PEND_MAX 4'hF
`define OCS_ERRQ_DEPTH 4'h8

`endif

// ==== design/ocs_pkg.sv ====
// Types shared by the command sync block.
package ocs_pkg;

	// Command classes handed over by the parser.
	typedef enum logic [3:0] {
		OCS_OP_SET = 4'h0,
		OCS_OP_QUERY = 4'h1,
		OCS_OP_SWEEP = 4'h2,
		OCS_OP_OPC = 4'h3,
		OCS_OP_OPCQ = 4'h4,
		OCS_OP_WAI = 4'h5,
		OCS_OP_CLS = 4'h6
	} ocs_op_t;

	// One parsed command.
	typedef struct packed {
		ocs_op_t op;
		logic overlapped;
		logic last_in_line;
		logic [7:0] arg;
	} ocs_cmd_t;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ocs_bus_t;

	// Dispatcher states.
	typedef enum logic [1:0] {
		OCS_S_IDLE = 2'b00,
		OCS_S_SEQ = 2'b01,
		OCS_S_DRAIN = 2'b10,
		OCS_S_DRAINQ = 2'b11
	} ocs_state_t;

	// Operation complete command states.
	typedef enum logic {
		OCS_OCIS = 1'b0,
		OCS_OCAS = 1'b1
	} ocs_opc_t;

endpackage

// ==== design/ocs_pending.sv ====
// Counter of overlapped operations still executing.
`timescale 1ns/10ps
`include "ocs_params.svh"
module ocs_pending import ocs_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Launch and completion pulses.
	input wire logic inc,
	input wire logic dec,
	// Count and flags.
	output logic [3:0] cnt,
	output logic zero,
	output logic full
);

	// ==========================================================================
	// Count update; a completion with nothing pending is ignored.
	wire logic do_dec;
	wire logic [3:0] next_cnt;
	assign do_dec = dec && (cnt != 4'h0);
	assign next_cnt = cnt + {3'h0, inc} - {3'h0, do_dec};
	assign zero = (cnt == 4'h0);
	assign full = (cnt == `OCS_PEND_MAX);

	// Count register.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Count never wraps through zero.
	count_nowrap_a: assert property (@(posedge clk_sys) disable iff (rst)
		(zero && dec && !inc) |=> zero)
		else $error("pending count wrapped below zero");

endmodule

// ==== design/ocs_status.sv ====
// Status byte summary and service request generation.
`timescale 1ns/10ps
`include "ocs_params.svh"
module ocs_status import ocs_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Summary bits, enable mask and request clear.
	input wire logic [7:0] stb_raw,
	input wire logic [7:0] sre,
	input wire logic clr,
	// Status byte and request.
	output logic [7:0] stb,
	output logic srq
);

	// ==========================================================================
	// Summary position and its enable bit take no part in the request.
	wire logic [7:0] sum_mask;
	wire logic [7:0] sre_used;
	wire logic rqs;
	wire logic [7:0] next_stb;
	wire logic [7:0] rise;
	assign sum_mask = 8'h01 << `OCS_STB_RQS;
	assign sre_used = sre & ~sum_mask;
	assign rqs = |(stb_raw & sre_used);
	assign next_stb = (stb_raw & ~sum_mask) | (rqs ? sum_mask : 8'h00);
	assign rise = next_stb & ~stb & sre_used;

	// Status byte and sticky request; a new rise wins over a clear.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stb <= 8'h00;
			srq <= 1'b0;
		end else begin
			stb <= next_stb;
			srq <= (srq && !clr) || (|rise);
		end
	end

	// An enabled rising bit raises the request on the next edge.
	srq_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
		(|(next_stb & ~stb & sre & ~sum_mask)) |=> srq)
		else $error("enabled status rise gave no request");

	// Enable bit 6 alone never raises a request.
	sre_six_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!srq && sre_used == 8'h00) |=> !srq)
		else $error("request raised with no usable enable");

endmodule

// ==== design/ocs_sync.sv ====
// Command synchronisation, event status, error queue and register port.
`timescale 1ns/10ps
`include "ocs_params.svh"
module ocs_sync import ocs_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire ocs_bus_t bus,
	output logic [7:0] rdata,
	// Commands from the parser.
	input wire logic cmd_valid,
	input wire ocs_cmd_t cmd,
	output logic cmd_ready,
	input wire logic msg_term_seen,
	// Execution units.
	output logic exec_start,
	output ocs_cmd_t exec_cmd,
	input wire logic exec_done,
	input wire logic op_done,
	// Completion query answer.
	output logic resp_valid,
	output logic [7:0] resp_data,
	input wire logic resp_ready,
	// Status sources.
	input wire logic [7:0] esr_evt,
	input wire logic err_valid,
	input wire logic [7:0] err_code,
	input wire logic ext_mav,
	input wire logic ques_sum,
	input wire logic oper_sum,
	// Status byte and service request.
	output logic [7:0] stb,
	output logic srq
);

	// ==========================================================================
	// Registers.
	ocs_state_t state;
	ocs_state_t next_state;
	ocs_opc_t opc_state;
	logic [7:0] esr;
	logic [7:0] ese;
	logic [7:0] sre;
	logic [7:0] ctrl;
	logic [7:0] errq [0:7];
	logic [2:0] errq_wp;
	logic [2:0] errq_rp;
	logic [3:0] errq_cnt;
	logic [3:0] pend_cnt;
	logic pend_zero;
	logic pend_full;

	// ==========================================================================
	// Register port decode.
	wire logic wr_ese;
	wire logic wr_sre;
	wire logic wr_ctrl;
	wire logic rd_esr;
	wire logic rd_stb;
	wire logic rd_errq;
	assign wr_ese = bus.wr && (bus.addr == `OCS_ADDR_ESE);
	assign wr_sre = bus.wr && (bus.addr == `OCS_ADDR_SRE);
	assign wr_ctrl = bus.wr && (bus.addr == `OCS_ADDR_CTRL);
	assign rd_esr = bus.rd && (bus.addr == `OCS_ADDR_ESR);
	assign rd_stb = bus.rd && (bus.addr == `OCS_ADDR_STB);
	assign rd_errq = bus.rd && (bus.addr == `OCS_ADDR_ERRQ);

	// Mode bits chosen by software.
	wire logic defer;
	wire logic line_ovl;
	assign defer = ctrl[`OCS_CTRL_DEFER];
	assign line_ovl = ctrl[`OCS_CTRL_LINEOVL];

	// ==========================================================================
	// Command classification.
	wire logic accept;
	wire logic is_exec;
	wire logic is_ovl;
	wire logic launch_ovl;
	wire logic launch_seq;
	wire logic cls_exec;
	wire logic opc_exec;
	// Commands wait for the terminator in defer mode, and for room to count.
	assign cmd_ready = (state == OCS_S_IDLE) && !pend_full
		&& (!defer || msg_term_seen);
	assign accept = cmd_valid && cmd_ready;
	assign is_exec = (cmd.op == OCS_OP_SET) || (cmd.op == OCS_OP_QUERY)
		|| (cmd.op == OCS_OP_SWEEP);
	// Sweep start and flagged set or query commands never hold the queue. Inside a line,
	// setting commands may run side by side and so finish in any order.
	assign is_ovl = cmd.overlapped
		|| (cmd.op == OCS_OP_SWEEP)
		|| (line_ovl && (cmd.op == OCS_OP_SET) && !cmd.last_in_line);
	assign launch_ovl = accept && is_exec && is_ovl;
	assign launch_seq = accept && is_exec && !is_ovl;
	assign cls_exec = accept && (cmd.op == OCS_OP_CLS);
	assign opc_exec = accept && (cmd.op == OCS_OP_OPC);

	// Overlapped operations still in flight.
	ocs_pending u_pending (
		.clk_sys(clk_sys),
		.rst(rst),
		.inc(launch_ovl),
		.dec(op_done),
		.cnt(pend_cnt),
		.zero(pend_zero),
		.full(pend_full)
	);

	// ==========================================================================
	// Dispatcher next state: sequential commands hold it until done, the wait
	// command until nothing is pending, the completion query until then and no answer is held.
	always_comb begin
		next_state = state;
		case (state)
			OCS_S_IDLE: begin
				if (launch_seq) begin
					next_state = OCS_S_SEQ;
				end else if (accept && (cmd.op == OCS_OP_WAI)) begin
					next_state = OCS_S_DRAIN;
				end else if (accept && (cmd.op == OCS_OP_OPCQ)) begin
					next_state = OCS_S_DRAINQ;
				end
			end
			OCS_S_SEQ: begin
				if (exec_done) begin
					next_state = OCS_S_IDLE;
				end
			end
			OCS_S_DRAIN: begin
				if (pend_zero) begin
					next_state = OCS_S_IDLE;
				end
			end
			OCS_S_DRAINQ: begin
				if (pend_zero && !resp_valid) begin
					next_state = OCS_S_IDLE;
				end
			end
			default: begin
				next_state = OCS_S_IDLE;
			end
		endcase
	end

	// Dispatcher state and execution launch.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= OCS_S_IDLE;
			exec_start <= 1'b0;
			exec_cmd <= '0;
		end else begin
			state <= next_state;
			exec_start <= launch_ovl || launch_seq;
			if (launch_ovl || launch_seq) begin
				exec_cmd <= cmd;
			end
		end
	end

	// ==========================================================================
	// Completion query answer; loaded once nothing is pending and no answer is held.
	wire logic resp_load;
	assign resp_load = (state == OCS_S_DRAINQ) && pend_zero && !resp_valid;

	// Answer register, held until the output side takes it.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_data <= 8'h00;
		end else if (resp_load) begin
			resp_valid <= 1'b1;
			resp_data <= `OCS_OPCQ_VALUE;
		end else if (resp_ready) begin
			resp_valid <= 1'b0;
		end
	end

	// ==========================================================================
	// Operation complete: armed by the command, fired when nothing is pending,
	// dropped without firing by clear status.
	wire logic opc_fire;
	ocs_opc_t next_opc;
	assign opc_fire = (opc_state == OCS_OCAS) && pend_zero && !cls_exec;
	assign next_opc = cls_exec ? OCS_OCIS
		: opc_exec ? OCS_OCAS
		: opc_fire ? OCS_OCIS
		: opc_state;

	// Event status: a read or clear status empties it, new events win.
	wire logic [7:0] esr_set;
	wire logic [7:0] next_esr;
	assign esr_set = esr_evt | ({7'h00, opc_fire} << `OCS_ESR_OPC);
	assign next_esr = ((rd_esr || cls_exec) ? 8'h00 : esr) | esr_set;

	// Completion state, event status and mask registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opc_state <= OCS_OCIS;
			esr <= 8'h00;
			ese <= `OCS_ESE_RST;
			sre <= `OCS_SRE_RST;
			ctrl <= `OCS_CTRL_RST;
		end else begin
			opc_state <= next_opc;
			esr <= next_esr;
			if (wr_ese) begin
				ese <= bus.wdata;
			end
			if (wr_sre) begin
				sre <= bus.wdata;
			end
			if (wr_ctrl) begin
				ctrl <= bus.wdata;
			end
		end
	end

	// ==========================================================================
	// Error queue: full drops new codes, clear status empties it.
	wire logic errq_push;
	wire logic errq_pop;
	assign errq_push = err_valid && (errq_cnt != `OCS_ERRQ_DEPTH);
	assign errq_pop = rd_errq && (errq_cnt != 4'h0);

	// A code that arrives with clear status survives as the first entry.
	wire logic errq_wr;
	wire logic [2:0] errq_widx;
	assign errq_wr = errq_push || (err_valid && cls_exec);
	assign errq_widx = cls_exec ? 3'h0 : errq_wp;

	// Queue pointers and fill level.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			errq_wp <= 3'h0;
			errq_rp <= 3'h0;
			errq_cnt <= 4'h0;
		end else if (cls_exec) begin
			errq_wp <= {2'h0, err_valid};
			errq_rp <= 3'h0;
			errq_cnt <= {3'h0, err_valid};
		end else begin
			errq_wp <= errq_wp + {2'h0, errq_push};
			errq_rp <= errq_rp + {2'h0, errq_pop};
			errq_cnt <= errq_cnt + {3'h0, errq_push} - {3'h0, errq_pop};
		end
	end

	// Queue storage.
	always_ff @(posedge clk_sys) begin
		if (errq_wr) begin
			errq[errq_widx] <= err_code;
		end
	end

	// ==========================================================================
	// Status byte sources; the summary bit is filled in by the status module.
	wire logic esb;
	wire logic mav;
	wire logic [7:0] stb_raw;
	assign esb = |(esr & ese);
	assign mav = resp_valid || ext_mav;
	assign stb_raw = ({7'h00, oper_sum} << `OCS_STB_OPER)
		| ({7'h00, esb} << `OCS_STB_ESB)
		| ({7'h00, mav} << `OCS_STB_MAV)
		| ({7'h00, ques_sum} << `OCS_STB_QUES)
		| ({7'h00, errq_cnt != 4'h0} << `OCS_STB_ERRQ);

	// Status byte, summary bit and service request.
	ocs_status u_status (
		.clk_sys(clk_sys),
		.rst(rst),
		.stb_raw(stb_raw),
		.sre(sre),
		.clr(rd_stb || cls_exec),
		.stb(stb),
		.srq(srq)
	);

	// ==========================================================================
	// Read selection; unmapped offsets read zero.
	wire logic [7:0] state_word;
	wire logic [7:0] rsel;
	assign state_word = {pend_cnt, 1'b0, opc_state == OCS_OCAS, state};
	assign rsel = (bus.addr == `OCS_ADDR_ESR) ? esr
		: (bus.addr == `OCS_ADDR_ESE) ? ese
		: (bus.addr == `OCS_ADDR_SRE) ? sre
		: (bus.addr == `OCS_ADDR_STB) ? stb
		: (bus.addr == `OCS_ADDR_ERRQ) ? (errq_cnt != 4'h0 ? errq[errq_rp] : 8'h00)
		: (bus.addr == `OCS_ADDR_CTRL) ? ctrl
		: (bus.addr == `OCS_ADDR_STATE) ? state_word
		: 8'h00;

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= bus.rd ? rsel : 8'h00;
		end
	end

	// ==========================================================================
	// Checks.

	// A sequential command is launched and blocks the next one.
	seq_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		launch_seq |=> (exec_start && !cmd_ready && state == OCS_S_SEQ))
		else $error("sequential command did not block the queue");

	// An overlapped launch leaves the queue open and counts one more.
	ovl_open_a: assert property (@(posedge clk_sys) disable iff (rst)
		(launch_ovl && !op_done) |=>
		(state == OCS_S_IDLE && pend_cnt == $past(pend_cnt) + 4'h1))
		else $error("overlapped launch mishandled");

	// A sweep start is always counted as pending.
	sweep_ovl_a: assert property (@(posedge clk_sys) disable iff (rst)
		(accept && cmd.op == OCS_OP_SWEEP) |=> (!pend_zero && exec_start))
		else $error("sweep start was not overlapped");

	// Defer mode takes nothing before the terminator.
	defer_term_a: assert property (@(posedge clk_sys) disable iff (rst)
		(defer && !msg_term_seen) |-> !accept)
		else $error("command taken before terminator in defer mode");

	// Armed completion with nothing pending sets bit 0 and disarms.
	opc_set_a: assert property (@(posedge clk_sys) disable iff (rst)
		(opc_state == OCS_OCAS && pend_zero && !cls_exec
		&& !opc_exec) |=>
		(esr[`OCS_ESR_OPC] && opc_state == OCS_OCIS))
		else $error("completion bit not set");

	// Clear status leaves completion idle and unset by it.
	cls_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cls_exec && !esr_evt[`OCS_ESR_OPC]) |=>
		(opc_state == OCS_OCIS && !esr[`OCS_ESR_OPC]))
		else $error("clear status kept the completion request");

	// The completion query answers 1 and releases the queue on the same edge.
	opcq_resp_a: assert property (@(posedge clk_sys) disable iff (rst)
		resp_load |=> (resp_valid && resp_data == `OCS_OPCQ_VALUE
		&& state == OCS_S_IDLE))
		else $error("completion query answer wrong");

	// The wait command holds while work is pending.
	wai_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == OCS_S_DRAIN && !pend_zero) |=>
		(state == OCS_S_DRAIN && !cmd_ready))
		else $error("wait command released early");

	// An event status read returns the old value and clears it.
	esr_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rd_esr && !cls_exec) |=> (rdata == $past(esr)
		&& esr == $past(esr_set)))
		else $error("event status read did not clear");

	// Enabled event bits show as the summary one cycle on.
	esb_sum_a: assert property (@(posedge clk_sys) disable iff (rst)
		(|(esr & ese)) |=> stb[`OCS_STB_ESB])
		else $error("event summary bit missing");

endmodule

// ==== test/ocs_exec_model.sv ====
// Behavioural execution units that finish the commands the block launches.
`timescale 1ns/10ps
module ocs_exec_model import ocs_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Launch from the block.
	input wire logic exec_start,
	input wire ocs_cmd_t exec_cmd,
	// Run times in cycles, set by the bench for prompt or slow answers.
	input wire logic [7:0] seq_cycles,
	input wire logic [7:0] ovl_cycles,
	// Completion pulses.
	output logic exec_done,
	output logic op_done
);
	int seq_left;
	int now;
	int due[$];

	// ==========================================================================
	// Sequential work counts down; overlapped work retires in launch order.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seq_left = 0;
			now = 0;
			due.delete();
			exec_done <= 1'b0;
			op_done <= 1'b0;
		end else begin
			now = now + 1;
			exec_done <= (seq_left == 1);
			if (seq_left > 0) begin
				seq_left = seq_left - 1;
			end
			// One finished background operation is reported per cycle.
			op_done <= (due.size() > 0 && due[0] <= now);
			if (due.size() > 0 && due[0] <= now) begin
				void'(due.pop_front());
			end
			// A sweep always runs in the background, like any flagged
			// command; a setting that is not last in its line does too,
			// as the bench only sends those with line mode on.
			if (exec_start && (exec_cmd.overlapped
				|| exec_cmd.op == OCS_OP_SWEEP
				|| !exec_cmd.last_in_line)) begin
				due.push_back(now + int'(ovl_cycles));
			end else if (exec_start) begin
				seq_left = int'(seq_cycles);
			end
		end
	end
endmodule

// ==== test/test_overlapped_command_sync.sv ====
// Self-checking bench for the command synchronisation block.
`timescale 1ns/10ps
`include "ocs_params.svh"
module test_overlapped_command_sync import ocs_pkg::*; ();
	logic clk_sys, rst, cmd_valid, cmd_ready, msg_term_seen, exec_start;
	logic exec_done, op_done, resp_valid, resp_ready, err_valid, srq;
	logic ext_mav, ques_sum, oper_sum, last_flag;
	logic [7:0] rdata, resp_data, esr_evt, err_code, stb, d;
	logic [2:0] flags;
	ocs_bus_t bus;
	ocs_cmd_t cmd, exec_cmd;
	int fail_count, tests_run, n;

	// Flags the bench waits on: answer, service request, command ready.
	assign flags = {resp_valid, srq, cmd_ready};

	// ==========================================================================
	// Design and execution units.
	ocs_sync DUT (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.msg_term_seen(msg_term_seen), .exec_start(exec_start),
		.exec_cmd(exec_cmd), .exec_done(exec_done), .op_done(op_done),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.resp_ready(resp_ready), .esr_evt(esr_evt), .err_valid(err_valid),
		.err_code(err_code), .ext_mav(ext_mav), .ques_sum(ques_sum),
		.oper_sum(oper_sum), .stb(stb), .srq(srq));
	ocs_exec_model units (.clk_sys(clk_sys), .rst(rst),
		.exec_start(exec_start), .exec_cmd(exec_cmd),
		.seq_cycles(8'h0A), .ovl_cycles(8'h1E),
		.exec_done(exec_done), .op_done(op_done));

	// ==========================================================================
	// Shared tasks.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	// Offers a command and returns just after the edge that took it.
	task automatic send(input ocs_op_t op, input logic ovl);
		logic ok;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, overlapped: ovl,
			last_in_line: last_flag, arg: 8'h00};
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			#1;
			ok = (cmd_ready === 1'b1);
			@(posedge clk_sys);
		end
		cmd_valid <= 1'b0;
		#1;
		chk({7'h00, ok}, 8'h01);
	endtask

	task automatic wait_bit(input int i, output int cnt);
		cnt = 0;
		while (flags[i] !== 1'b1 && cnt < 500) begin
			@(posedge clk_sys);
			#1;
			cnt++;
		end
		chk({7'h00, flags[i]}, 8'h01);
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================================
	// Clock and watchdog.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end

	// ==========================================================================
	// Test sequence.
	initial begin
		rst = 1'b1;
		bus = '0;
		cmd_valid = 1'b0;
		cmd = '0;
		last_flag = 1'b1;
		msg_term_seen = 1'b0;
		resp_ready = 1'b0;
		esr_evt = 8'h00;
		err_valid = 1'b0;
		err_code = 8'h00;
		ext_mav = 1'b0;
		ques_sum = 1'b0;
		oper_sum = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		rd_reg(`OCS_ADDR_ESE, d);
		chk(d, 8'h00);
		rd_reg(`OCS_ADDR_STB, d);
		chk(d, 8'h00);
		wr_reg(`OCS_ADDR_ESE, 8'h01);
		rd_reg(`OCS_ADDR_ESE, d);
		chk(d, 8'h01);
		wr_reg(`OCS_ADDR_SRE, 8'h20);
		end_test("reset");
		send(OCS_OP_SET, 1'b0);
		chk({7'h00, cmd_ready}, 8'h00);
		wait_bit(0, n);
		chk({7'h00, n >= 8}, 8'h01);
		end_test("sequential");
		send(OCS_OP_SWEEP, 1'b0);
		chk({7'h00, cmd_ready}, 8'h01);
		chk({7'h00, exec_start}, 8'h01);
		send(OCS_OP_SET, 1'b1);
		chk({7'h00, cmd_ready}, 8'h01);
		send(OCS_OP_OPC, 1'b0);
		rd_reg(`OCS_ADDR_ESR, d);
		chk(d, 8'h00);
		wait_bit(1, n);
		rd_reg(`OCS_ADDR_STB, d);
		chk(d & 8'h20, 8'h20);
		@(posedge clk_sys);
		esr_evt <= 8'h04;
		@(posedge clk_sys);
		esr_evt <= 8'h00;
		#1;
		chk({7'h00, srq}, 8'h00);
		rd_reg(`OCS_ADDR_ESR, d);
		chk(d, 8'h05);
		rd_reg(`OCS_ADDR_ESR, d);
		chk(d, 8'h00);
		end_test("overlapped");
		send(OCS_OP_SWEEP, 1'b0);
		send(OCS_OP_OPC, 1'b0);
		send(OCS_OP_CLS, 1'b0);
		repeat (50) @(posedge clk_sys);
		rd_reg(`OCS_ADDR_ESR, d);
		chk(d, 8'h00);
		chk({7'h00, srq}, 8'h00);
		end_test("clear");
		send(OCS_OP_SWEEP, 1'b0);
		send(OCS_OP_OPCQ, 1'b0);
		chk({7'h00, cmd_ready}, 8'h00);
		wait_bit(2, n);
		chk(resp_data, `OCS_OPCQ_VALUE);
		chk({7'h00, cmd_ready}, 8'h01);
		@(posedge clk_sys);
		resp_ready <= 1'b1;
		@(posedge clk_sys);
		resp_ready <= 1'b0;
		#1;
		chk({7'h00, resp_valid}, 8'h00);
		end_test("query");
		send(OCS_OP_SWEEP, 1'b0);
		send(OCS_OP_WAI, 1'b0);
		chk({7'h00, cmd_ready}, 8'h00);
		wait_bit(0, n);
		chk({7'h00, n >= 20}, 8'h01);
		end_test("wait");
		wr_reg(`OCS_ADDR_SRE, 8'h40);
		@(posedge clk_sys);
		ext_mav <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk({7'h00, srq}, 8'h00);
		@(posedge clk_sys);
		ext_mav <= 1'b0;
		wr_reg(`OCS_ADDR_SRE, 8'h10);
		@(posedge clk_sys);
		ext_mav <= 1'b1;
		wait_bit(1, n);
		rd_reg(`OCS_ADDR_STB, d);
		chk(d & 8'h10, 8'h10);
		chk(stb & 8'h50, 8'h50);
		@(posedge clk_sys);
		ext_mav <= 1'b0;
		end_test("request mask");
		@(posedge clk_sys);
		err_valid <= 1'b1;
		err_code <= 8'h5A;
		@(posedge clk_sys);
		err_valid <= 1'b0;
		rd_reg(`OCS_ADDR_ERRQ, d);
		chk(d, 8'h5A);
		rd_reg(`OCS_ADDR_ERRQ, d);
		chk(d, 8'h00);
		end_test("error queue");
		wr_reg(`OCS_ADDR_CTRL, 8'h01);
		@(posedge clk_sys);
		#1;
		chk({7'h00, cmd_ready}, 8'h00);
		@(posedge clk_sys);
		msg_term_seen <= 1'b1;
		#1;
		chk({7'h00, cmd_ready}, 8'h01);
		wr_reg(`OCS_ADDR_CTRL, 8'h02);
		end_test("defer");
		last_flag = 1'b0;
		send(OCS_OP_SET, 1'b0);
		chk({7'h00, cmd_ready}, 8'h01);
		rd_reg(`OCS_ADDR_STATE, d);
		chk(d, 8'h10);
		last_flag = 1'b1;
		wr_reg(`OCS_ADDR_CTRL, 8'h00);
		end_test("line order");
		wrap_up();
	end
endmodule
